/* File: scb_pkg.sv */
package scb_pkg;

    // Register byte addresses
    localparam logic [5:0] OFS_TX_FIRST  = 6'h00;
    localparam logic [5:0] OFS_TX_SECOND = 6'h04;
    localparam logic [5:0] OFS_TX_THIRD  = 6'h08;
    localparam logic [5:0] OFS_CONTROL   = 6'h0C;
    localparam logic [5:0] OFS_RX_FIRST  = 6'h10;
    localparam logic [5:0] OFS_RX_SECOND = 6'h14;
    localparam logic [5:0] OFS_RX_THIRD  = 6'h18;
    localparam logic [5:0] OFS_WIDTH     = 6'h1C;
    localparam logic [5:0] OFS_PORT3     = 6'h20;
    localparam logic [5:0] OFS_STATUS    = 6'h24;

    // Control word, port 3 and width register fields
    localparam int CB_GO  = 7;
    localparam int CB_SEL = 6;
    localparam int CB_ANS = 5;
    localparam int CB_L3  = 3;
    localparam int CB_L2  = 2;
    localparam int CB_L1  = 1;
    localparam int CB_L0  = 0;
    localparam int P3_HOLD = 6;
    localparam int WIDTH_W = 7;

    // Status fields
    localparam int ST_BUSY  = 0;
    localparam int ST_STR3  = 1;
    localparam int ST_RXACT = 2;

    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Timing
    localparam int CLK_NS       = 100;
    localparam int STROBE_NS    = 500;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_BITS   = 24;
    localparam int ANS_DELAY    = 5;
    localparam int UNIT_PERIODS = 100;
    localparam int SYN_DIV      = 8;

    localparam logic [4:0] LAST_BIT  = 5'(FRAME_BITS - 1);
    localparam logic [4:0] GAP_LAST  = 5'(ANS_DELAY - 2);
    localparam logic [2:0] PULSE_LEN = 3'(STROBE_CYC);
    localparam logic [6:0] UNIT_LAST = 7'(UNIT_PERIODS - 1);
    localparam logic [2:0] DIV_LAST  = 3'(SYN_DIV - 1);
    localparam int         DIV_HALF  = 2;

    typedef enum logic [2:0] {
        SCB_IDLE,
        SCB_SHIFT,
        SCB_LATCH,
        SCB_GAP,
        SCB_RECV
    } scb_state_t;

endpackage : scb_pkg

/* File: scb_sync_if.sv */
`timescale 1ns/1ps
interface scb_sync_if;
    logic bclk_fall;
    logic data_in;

    modport prod (output bclk_fall, output data_in);
    modport cons (input bclk_fall, input data_in);
endinterface : scb_sync_if

/* File: scb_pin_sync.sv */
`timescale 1ns/1ps
module scb_pin_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic bclk_pin,
    input  wire logic data_pin,
    scb_sync_if.prod  sif
);
    logic [1:0] bclk_sync_r;
    logic [1:0] data_sync_r;
    logic       bclk_last_r;
    logic [1:0] bclk_sync_nxt;
    logic [1:0] data_sync_nxt;
    logic       bclk_last_nxt;

    always_comb begin
        bclk_sync_nxt = {bclk_sync_r[0], bclk_pin};
        data_sync_nxt = {data_sync_r[0], data_pin};
        bclk_last_nxt = bclk_sync_r[1];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bclk_sync_r <= 2'h0;
            data_sync_r <= 2'h0;
            bclk_last_r <= 1'b0;
        end else begin
            bclk_sync_r <= bclk_sync_nxt;
            data_sync_r <= data_sync_nxt;
            bclk_last_r <= bclk_last_nxt;
        end
    end

    // Falling edge of the bus clock
    assign sif.bclk_fall = bclk_last_r & ~bclk_sync_r[1];
    assign sif.data_in   = data_sync_r[1];
endmodule : scb_pin_sync

/* File: scb_master.sv */
`timescale 1ns/1ps
module scb_master
    import scb_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        BUS_CLOCK,
    input  wire logic        DATA_IN,
    output logic             DATA_OUT,
    output logic             DATA_OE,
    output logic             STROBE_ZERO,
    output logic             STROBE_ONE,
    output logic             STROBE_TWO,
    output logic             STROBE_THREE,
    output logic             SYN_CLK,
    output logic             SYN_DATA,
    output logic             SEND_DONE,
    output logic             RECV_DONE
);
    import scb_pkg::*;

    scb_sync_if sif ();

    scb_pin_sync u_sync (
        .clk      (CLOCK),
        .nrst     (NRST),
        .bclk_pin (BUS_CLOCK),
        .data_pin (DATA_IN),
        .sif      (sif.prod)
    );

    scb_state_t  state_r,   state_nxt;
    logic [7:0]  tx_r [3],  tx_nxt [3];
    logic [7:0]  rx_r [3],  rx_nxt [3];
    logic [7:0]  ctrl_r,    ctrl_nxt;
    logic [6:0]  width_r,   width_nxt;
    logic [7:0]  port3_r,   port3_nxt;
    logic [23:0] tsh_r,     tsh_nxt;
    logic [23:0] rsh_r,     rsh_nxt;
    logic [4:0]  cnt_r,     cnt_nxt;
    logic        main_r,    main_nxt;
    logic        ans_r,     ans_nxt;
    logic [3:0]  lsel_r,    lsel_nxt;
    logic [2:0]  div_r,     div_nxt;
    logic [3:0]  pulse_r,   pulse_nxt;
    logic [2:0]  plen_r,    plen_nxt;
    logic        s3_r,      s3_nxt;
    logic [6:0]  pre_r,     pre_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    logic        wait_r,    wait_nxt;
    logic        dout_r,    dout_nxt;
    logic        oe_r,      oe_nxt;
    logic [3:0]  str_r,     str_nxt;
    logic        sclk_r,    sclk_nxt;
    logic        sdat_r,    sdat_nxt;
    logic        sdone_r,   sdone_nxt;
    logic        rdone_r,   rdone_nxt;

    logic        fall;
    logic        tick;
    logic        ack;
    logic        wr;
    logic [23:0] rword;

    always_comb begin
        fall  = sif.bclk_fall;
        tick  = fall && (main_r || div_r == DIV_LAST);
        ack   = (AVS_READ || AVS_WRITE) && !wait_r;
        wr    = AVS_WRITE && ack && AVS_BYTEENABLE[0];
        rword = {rsh_r[22:0], sif.data_in};

        state_nxt = state_r;
        tx_nxt    = tx_r;
        rx_nxt    = rx_r;
        ctrl_nxt  = ctrl_r;
        width_nxt = width_r;
        port3_nxt = port3_r;
        tsh_nxt   = tsh_r;
        rsh_nxt   = rsh_r;
        cnt_nxt   = cnt_r;
        main_nxt  = main_r;
        ans_nxt   = ans_r;
        lsel_nxt  = lsel_r;
        div_nxt   = div_r;
        pulse_nxt = pulse_r;
        plen_nxt  = plen_r;
        s3_nxt    = s3_r;
        pre_nxt   = pre_r;
        dout_nxt  = dout_r;
        oe_nxt    = oe_r;
        sclk_nxt  = !main_r && div_r[DIV_HALF] &&
                    (state_r == SCB_LATCH || (state_r == SCB_SHIFT && cnt_r != 5'h00));
        sdat_nxt  = sdat_r;
        sdone_nxt = 1'b0;
        rdone_nxt = 1'b0;

        // Avalon slave: one wait cycle, then answer
        wait_nxt  = !((AVS_READ || AVS_WRITE) && wait_r);
        rdata_nxt = rdata_r;
        if ((AVS_READ || AVS_WRITE) && wait_r) begin
            case (AVS_ADDRESS)
                OFS_TX_FIRST:  rdata_nxt = {24'h00_0000, tx_r[0]};
                OFS_TX_SECOND: rdata_nxt = {24'h00_0000, tx_r[1]};
                OFS_TX_THIRD:  rdata_nxt = {24'h00_0000, tx_r[2]};
                OFS_CONTROL:   rdata_nxt = {24'h00_0000, ctrl_r};
                OFS_RX_FIRST:  rdata_nxt = {24'h00_0000, rx_r[0]};
                OFS_RX_SECOND: rdata_nxt = {24'h00_0000, rx_r[1]};
                OFS_RX_THIRD:  rdata_nxt = {24'h00_0000, rx_r[2]};
                OFS_WIDTH:     rdata_nxt = {25'h000_0000, width_r};
                OFS_PORT3:     rdata_nxt = {24'h00_0000, port3_r};
                OFS_STATUS:    rdata_nxt = {29'h0000_0000,
                                            state_r == SCB_GAP || state_r == SCB_RECV,
                                            str_r[3], state_r != SCB_IDLE};
                default:       rdata_nxt = WORD_ZERO;
            endcase
        end

        if (wr) begin
            case (AVS_ADDRESS)
                OFS_TX_FIRST:  tx_nxt[0] = AVS_WRITEDATA[7:0];
                OFS_TX_SECOND: tx_nxt[1] = AVS_WRITEDATA[7:0];
                OFS_TX_THIRD:  tx_nxt[2] = AVS_WRITEDATA[7:0];
                OFS_CONTROL:   ctrl_nxt  = AVS_WRITEDATA[7:0];
                OFS_WIDTH:     width_nxt = AVS_WRITEDATA[WIDTH_W-1:0];
                OFS_PORT3:     port3_nxt = AVS_WRITEDATA[7:0];
                default: begin
                end
            endcase
        end

        // Strobe pulse of fixed length
        if (plen_r != 3'h0) begin
            plen_nxt = plen_r - 3'h1;
            if (plen_r == 3'h1) begin
                pulse_nxt = 4'h0;
            end
        end

        // Strobe three width countdown on the main bus
        if (s3_r && fall) begin
            if (pre_r == UNIT_LAST) begin
                pre_nxt = 7'h00;
                if (width_nxt != 7'h00) begin
                    width_nxt = width_nxt - 7'h01;
                end
            end else begin
                pre_nxt = pre_r + 7'h01;
            end
        end
        if (s3_r && width_nxt == 7'h00 && !port3_nxt[P3_HOLD]) begin
            s3_nxt = 1'b0;
        end

        if (!main_r && (state_r == SCB_SHIFT || state_r == SCB_LATCH) && fall) begin
            div_nxt = div_r + 3'h1;
        end

        case (state_r)
            SCB_IDLE: begin
                if (ctrl_r[CB_GO]) begin
                    state_nxt = SCB_SHIFT;
                    tsh_nxt   = {tx_r[0], tx_r[1], tx_r[2]};
                    cnt_nxt   = 5'h00;
                    div_nxt   = 3'h0;
                    main_nxt  = ctrl_r[CB_SEL];
                    ans_nxt   = ctrl_r[CB_SEL] && ctrl_r[CB_ANS];
                    lsel_nxt  = ctrl_r[3:0];
                end
            end
            SCB_SHIFT: begin
                if (tick) begin
                    if (main_r) begin
                        dout_nxt = tsh_r[FRAME_BITS-1];
                        oe_nxt   = 1'b1;
                    end else begin
                        sdat_nxt = tsh_r[FRAME_BITS-1];
                    end
                    tsh_nxt = {tsh_r[22:0], 1'b0};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == LAST_BIT) begin
                        state_nxt = SCB_LATCH;
                    end
                end
            end
            SCB_LATCH: begin
                if (tick) begin
                    oe_nxt    = 1'b0;
                    sdat_nxt  = 1'b0;
                    sdone_nxt = 1'b1;
                    ctrl_nxt  = BYTE_RST;
                    cnt_nxt   = 5'h00;
                    if (main_r && lsel_r[1:0] == 2'h0) begin
                        s3_nxt  = 1'b1;
                        pre_nxt = 7'h00;
                    end else begin
                        pulse_nxt = main_r ? {2'h0, lsel_r[CB_L1], lsel_r[CB_L0]}
                                           : {lsel_r[CB_L3], lsel_r[CB_L2], 2'h0};
                        plen_nxt  = PULSE_LEN;
                    end
                    state_nxt = ans_r ? SCB_GAP : SCB_IDLE;
                end
            end
            SCB_GAP: begin
                if (fall) begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == GAP_LAST) begin
                        state_nxt = SCB_RECV;
                        cnt_nxt   = 5'h00;
                    end
                end
            end
            SCB_RECV: begin
                if (fall) begin
                    rsh_nxt = rword;
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == LAST_BIT) begin
                        rx_nxt[0] = rword[23:16];
                        rx_nxt[1] = rword[15:8];
                        rx_nxt[2] = rword[7:0];
                        rdone_nxt = 1'b1;
                        state_nxt = SCB_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = SCB_IDLE;
            end
        endcase

        str_nxt = {pulse_nxt[3] | s3_nxt, pulse_nxt[2:0]};
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state_r <= SCB_IDLE;
            tx_r    <= '{BYTE_RST, BYTE_RST, BYTE_RST};
            rx_r    <= '{BYTE_RST, BYTE_RST, BYTE_RST};
            ctrl_r  <= BYTE_RST;
            width_r <= 7'h00;
            port3_r <= BYTE_RST;
            tsh_r   <= 24'h00_0000;
            rsh_r   <= 24'h00_0000;
            cnt_r   <= 5'h00;
            main_r  <= 1'b0;
            ans_r   <= 1'b0;
            lsel_r  <= 4'h0;
            div_r   <= 3'h0;
            pulse_r <= 4'h0;
            plen_r  <= 3'h0;
            s3_r    <= 1'b0;
            pre_r   <= 7'h00;
            rdata_r <= WORD_ZERO;
            wait_r  <= 1'b1;
            dout_r  <= 1'b0;
            oe_r    <= 1'b0;
            str_r   <= 4'h0;
            sclk_r  <= 1'b0;
            sdat_r  <= 1'b0;
            sdone_r <= 1'b0;
            rdone_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tx_r    <= tx_nxt;
            rx_r    <= rx_nxt;
            ctrl_r  <= ctrl_nxt;
            width_r <= width_nxt;
            port3_r <= port3_nxt;
            tsh_r   <= tsh_nxt;
            rsh_r   <= rsh_nxt;
            cnt_r   <= cnt_nxt;
            main_r  <= main_nxt;
            ans_r   <= ans_nxt;
            lsel_r  <= lsel_nxt;
            div_r   <= div_nxt;
            pulse_r <= pulse_nxt;
            plen_r  <= plen_nxt;
            s3_r    <= s3_nxt;
            pre_r   <= pre_nxt;
            rdata_r <= rdata_nxt;
            wait_r  <= wait_nxt;
            dout_r  <= dout_nxt;
            oe_r    <= oe_nxt;
            str_r   <= str_nxt;
            sclk_r  <= sclk_nxt;
            sdat_r  <= sdat_nxt;
            sdone_r <= sdone_nxt;
            rdone_r <= rdone_nxt;
        end
    end

    assign AVS_READDATA    = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign DATA_OUT        = dout_r;
    assign DATA_OE         = oe_r;
    assign STROBE_ZERO     = str_r[0];
    assign STROBE_ONE      = str_r[1];
    assign STROBE_TWO      = str_r[2];
    assign STROBE_THREE    = str_r[3];
    assign SYN_CLK         = sclk_r;
    assign SYN_DATA        = sdat_r;
    assign SEND_DONE       = sdone_r;
    assign RECV_DONE       = rdone_r;
endmodule : scb_master

/* File: scb_master_assertions.sv */
`timescale 1ns/1ps
module scb_master_assertions
    import scb_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        NRST,
    input wire logic [5:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        DATA_OE,
    input wire logic        STROBE_ZERO,
    input wire logic        STROBE_ONE,
    input wire logic        STROBE_TWO,
    input wire logic        STROBE_THREE,
    input wire logic        SEND_DONE,
    input wire logic        RECV_DONE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    logic       ans_r, ans_nxt, hold_r, hold_nxt, wr_ok;
    logic [8:0] snd_r, snd_nxt, oe_r, oe_nxt;
    assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    always_comb begin
        ans_nxt = ans_r;
        hold_nxt = hold_r;
        if (wr_ok && AVS_ADDRESS == OFS_CONTROL && AVS_WRITEDATA[CB_GO])
            ans_nxt = AVS_WRITEDATA[CB_ANS] && AVS_WRITEDATA[CB_SEL];
        if (wr_ok && AVS_ADDRESS == OFS_PORT3)
            hold_nxt = AVS_WRITEDATA[P3_HOLD];
        snd_nxt = SEND_DONE ? 9'h000 : (snd_r == 9'h1FF ? snd_r : snd_r + 9'h001);
        oe_nxt = DATA_OE ? oe_r + 9'h001 : 9'h000;
    end
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ans_r <= 1'b0;
            hold_r <= 1'b0;
            snd_r <= 9'h000;
            oe_r <= 9'h000;
        end else begin
            ans_r <= ans_nxt;
            hold_r <= hold_nxt;
            snd_r <= snd_nxt;
            oe_r <= oe_nxt;
        end
    end
    a_done_strobe: assert property (SEND_DONE |->
        STROBE_ZERO || STROBE_ONE || STROBE_TWO || STROBE_THREE) else $error("no strobe");
    a_done_oe_off: assert property (SEND_DONE |-> !DATA_OE) else $error("line driven");
    a_zero_rise: assert property ($rose(STROBE_ZERO) |-> SEND_DONE) else $error("rise");
    a_send_once: assert property (SEND_DONE |=> !SEND_DONE) else $error("send pulse");
    a_zero_pulse: assert property ($rose(STROBE_ZERO) |->
        STROBE_ZERO [*5] ##1 !STROBE_ZERO) else $error("strobe zero length");
    a_one_pulse: assert property ($rose(STROBE_ONE) |->
        STROBE_ONE [*5] ##1 !STROBE_ONE) else $error("strobe one length");
    a_recv_time: assert property (RECV_DONE |->
        snd_r >= 9'h0D7 && snd_r <= 9'h0E8) else $error("receive timing");
    a_recv_asked: assert property (RECV_DONE |-> ans_r) else $error("unasked");
    a_frame_len: assert property ($fell(DATA_OE) |->
        oe_r >= 9'h0BC && oe_r <= 9'h0C4) else $error("frame length");
    a_hold_keep: assert property (STROBE_THREE && hold_nxt |=> STROBE_THREE)
        else $error("hold lost");
    a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("no answer");
endmodule : scb_master_assertions

bind scb_master scb_master_assertions u_chk (.CLOCK(CLOCK), .NRST(NRST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .DATA_OE(DATA_OE), .STROBE_ZERO(STROBE_ZERO),
    .STROBE_ONE(STROBE_ONE), .STROBE_TWO(STROBE_TWO), .STROBE_THREE(STROBE_THREE),
    .SEND_DONE(SEND_DONE), .RECV_DONE(RECV_DONE));

/* File: scb_slave_model.sv */
`timescale 1ns/1ps
module scb_slave_model (
    output logic        bus_clk,
    input  wire logic   data_out,
    input  wire logic   data_oe,
    input  wire logic   strobe,
    input  wire logic [23:0] answer,
    output logic        line,
    output logic [23:0] got
);
    logic drv;
    int   fc;
    initial begin
        bus_clk = 1'b1;
        drv = 1'b0;
        fc = 99;
        got = 24'h00_0000;
        forever #400 bus_clk = ~bus_clk;
    end
    assign line = data_oe ? data_out : drv;
    always @(posedge bus_clk) if (data_oe) got <= {got[22:0], data_out};
    always @(posedge strobe) fc = 0;
    always @(negedge bus_clk) if (fc < 99) fc = fc + 1;
    always @(posedge bus_clk) drv <= (fc >= 4 && fc <= 27) ? answer[27 - fc] : ~drv;
endmodule : scb_slave_model

/* File: scb_master_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module scb_master_test;
    import scb_pkg::*;
    logic        CLOCK, NRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, BUS_CLOCK, DATA_IN;
    logic [5:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
    logic [3:0]  AVS_BYTEENABLE;
    logic        DATA_OUT, DATA_OE, STROBE_ZERO, STROBE_ONE, STROBE_TWO, STROBE_THREE;
    logic        SYN_CLK, SYN_DATA, SEND_DONE, RECV_DONE;
    logic [23:0] got, syn_got;
    always @(posedge SYN_CLK) syn_got <= {syn_got[22:0], SYN_DATA};
    logic [5:0]  rlist [5] = '{OFS_RX_FIRST, OFS_RX_SECOND, OFS_RX_THIRD, OFS_STATUS, 6'h3C};
    int          err_count = 0;
    int          num_checks = 0;
    int          n;
    scb_master dut (.CLOCK(CLOCK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .BUS_CLOCK(BUS_CLOCK), .DATA_IN(DATA_IN),
        .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .STROBE_ZERO(STROBE_ZERO),
        .STROBE_ONE(STROBE_ONE), .STROBE_TWO(STROBE_TWO), .STROBE_THREE(STROBE_THREE),
        .SYN_CLK(SYN_CLK), .SYN_DATA(SYN_DATA), .SEND_DONE(SEND_DONE), .RECV_DONE(RECV_DONE));
    scb_slave_model u_slave (.bus_clk(BUS_CLOCK), .data_out(DATA_OUT), .data_oe(DATA_OE),
        .strobe(STROBE_ZERO | STROBE_ONE), .answer(24'h5A_C3E7), .line(DATA_IN), .got(got));
    task final_report;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge CLOCK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h00_0000, d};
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge CLOCK);
            k++;
        end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (k >= 50) begin
            err_count++;
            final_report();
        end
    endtask : bus
    task automatic wait_hi(ref logic s, input int lim);
        int k;
        k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(posedge CLOCK);
            k++;
        end
        if (k >= lim) begin
            err_count++;
            final_report();
        end
    endtask : wait_hi
    task automatic frame(input logic [7:0] c, input logic [23:0] w);
        bus(1'b1, OFS_TX_FIRST, w[23:16]);
        bus(1'b1, OFS_TX_SECOND, w[15:8]);
        bus(1'b1, OFS_TX_THIRD, w[7:0]);
        bus(1'b1, OFS_CONTROL, c);
        wait_hi(SEND_DONE, 2500);
    endtask : frame
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    initial begin
        NRST = 1'b0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_ADDRESS = 6'h00;
        AVS_WRITEDATA = WORD_ZERO;
        AVS_BYTEENABLE = 4'h1;
        repeat (2) @(posedge CLOCK);
        NRST <= 1'b1;
        repeat (4) @(posedge CLOCK);
        foreach (rlist[i]) begin
            bus(1'b0, rlist[i], 8'h00);
            `CHK(q, WORD_ZERO)
        end
        frame(8'hC2, 24'hA5_3C81);
        `CHK(got, 24'hA5_3C81)
        `CHK(STROBE_ONE, 1'b1)
        bus(1'b0, OFS_CONTROL, 8'h00);
        `CHK(q, WORD_ZERO)
        repeat (300) @(posedge CLOCK);
        bus(1'b0, OFS_RX_FIRST, 8'h00);
        `CHK(q, WORD_ZERO)
        frame(8'hC1, 24'h0F_F00F);
        `CHK(got, 24'h0F_F00F)
        `CHK(STROBE_ZERO, 1'b1)
        repeat (300) @(posedge CLOCK);
        frame(8'hE2, 24'h12_3456);
        `CHK(got, 24'h12_3456)
        wait_hi(RECV_DONE, 400);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, rlist[i], 8'h00);
            `CHK(q, {24'h00_0000, 24'h5A_C3E7 >> (16 - 8 * i)} & 32'h0000_00FF)
        end
        foreach (rlist[i]) if (i < 2) begin
            frame(i ? 8'h84 : 8'h88, i ? 24'h96_5A0F : 24'h3C_E1D2);
            `CHK(i ? STROBE_TWO : STROBE_THREE, 1'b1)
            `CHK(syn_got, i ? 24'h96_5A0F : 24'h3C_E1D2)
            repeat (20) @(posedge CLOCK);
        end
        bus(1'b1, OFS_WIDTH, 8'h01);
        frame(8'hC0, 24'hC3_0001);
        n = 0;
        while (STROBE_THREE === 1'b1 && n < 2000) begin
            @(posedge CLOCK);
            n++;
        end
        `CHK((n + 4) / 8, 100)
        bus(1'b1, OFS_WIDTH, 8'h02);
        frame(8'hC0, 24'h00_0000);
        frame(8'hC2, 24'h77_1188);
        `CHK(got, 24'h77_1188)
        `CHK(STROBE_THREE, 1'b1)
        bus(1'b0, OFS_STATUS, 8'h00);
        `CHK(q, 32'h0000_0001 << ST_STR3)
        bus(1'b1, OFS_WIDTH, 8'h00);
        repeat (3) @(posedge CLOCK);
        `CHK(STROBE_THREE, 1'b0)
        bus(1'b1, OFS_WIDTH, 8'h01);
        frame(8'hC0, 24'h00_0000);
        bus(1'b1, OFS_PORT3, 8'h40);
        repeat (1200) @(posedge CLOCK);
        `CHK(STROBE_THREE, 1'b1)
        bus(1'b1, OFS_PORT3, 8'h00);
        repeat (3) @(posedge CLOCK);
        `CHK(STROBE_THREE, 1'b0)
        final_report();
    end
endmodule : scb_master_test
